// ===== spc_port.sv
// six-bit general-purpose port with clock-out option and register slave
//
// Functional notes
// [R1] six data latch bits, untouched by reset
// [R2] direction 1 drives pin; reset clears all
// [R3] data read: latch if output, else pin
// [R4] latch always writable; input read unaffected
// [R5] pullup only when enabled and input
// [R6] pullup off whenever its enable is 0
// [R7] bit 6 reads the wakeup latch
// [R8] no storage for bit position six
// [R9] bit 2 is never driven out
// [R10] irq enabled: bit 2 reads 0, branch senses pin
// [R11] irq disabled: bit 2 reads pin, branch sees 1
// [R12] internal/rc mode: select drives clock on pin 4
// [R13] select ignored in crystal or external clock modes
// [R14] two-bit source field selects oscillator mode
// [R15] enabled pins act as keypad interrupt inputs
// [R16] software sets latch before turning output on
// [R17] external clock mode: pin 4 is port
// [R18] crystal mode: pin 4 belongs to amplifier
// [R19] single-cycle access; pins synchronised first
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "spc_defines.svh"
module spc_port #(
    parameter int WIDTH = 6
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst,
    input  wire logic             i_ce,
    input  wire logic [7:0]       i_addr,
    input  wire logic [7:0]       i_wdata,
    input  wire logic             i_wr,
    input  wire logic             i_rd,
    output logic      [7:0]       o_rdata,
    input  wire logic [WIDTH-1:0] i_pin,
    output logic      [WIDTH-1:0] o_pin,
    output logic      [WIDTH-1:0] o_pin_oe,
    output logic      [WIDTH-1:0] o_pullup_en,
    input  wire logic             i_wakeup_latch,
    input  wire logic             i_osc_clock_x4,
    output logic                  o_crystal_mode,
    output logic                  o_branch_irq_level,
    output logic      [WIDTH-1:0] o_keypad_irq,
    output logic                  o_irq
);
    logic [WIDTH-1:0] port_latch_r;
    logic [WIDTH-1:0] port_direction_r;
    logic [WIDTH-1:0] port_pullup_enable_r;
    logic             clock_out_pin_select_r;
    logic [WIDTH-1:0] keypad_irq_enable_r;
    logic [2:0]       option_r;
    logic [WIDTH-1:0] pin_meta_r;
    logic [WIDTH-1:0] pin_sync_r;
    logic [WIDTH-1:0] pin_prev_r;
    logic             wake_meta_r;
    logic             wake_sync_r;
    logic             wake_prev_r;
    logic [7:0]       irq_stat_r;
    logic [7:0]       irq_stat_nxt;
    logic [7:0]       irq_mask_r;
    logic [7:0]       rdata_r;

    wire              sel_data   = (i_addr == `SPC_OFF_DATA);
    wire              sel_dir    = (i_addr == `SPC_OFF_DIR);
    wire              sel_pullup = (i_addr == `SPC_OFF_PULLUP);
    wire              sel_kbi    = (i_addr == `SPC_OFF_KBI_EN);
    wire              sel_option = (i_addr == `SPC_OFF_OPTION);
    wire              sel_stat   = (i_addr == `SPC_OFF_IRQ_STAT);
    wire              sel_mask   = (i_addr == `SPC_OFF_IRQ_MASK);
    wire              wr_en      = i_ce & i_wr;
    wire              rd_en      = i_ce & i_rd;

    // oscillator source decode
    spc_pkg::spc_osc_e osc_mode;
    assign osc_mode = spc_pkg::spc_osc_e'(option_r[`SPC_BIT_OSC_HI:`SPC_BIT_OSC_LO]); // [R14]
    wire irq_pin_en  = option_r[`SPC_BIT_IRQ_EN];
    wire osc_int_rc  = (osc_mode == spc_pkg::SPC_OSC_INTERNAL)
                     | (osc_mode == spc_pkg::SPC_OSC_EXT_RC);
    wire crystal     = (osc_mode == spc_pkg::SPC_OSC_CRYSTAL);
    // clock out only in internal/rc with select; external clock leaves pin 4 as port
    wire clk_out     = osc_int_rc & clock_out_pin_select_r; // [R12] [R13] [R17]
    // pin 4 taken away from port use by clock out or crystal amplifier
    wire pin4_taken  = clk_out | crystal; // [R18]

    // per-pin drive and pullup
    logic [WIDTH-1:0] port_oe;
    logic [WIDTH-1:0] port_read;
    logic [WIDTH-1:0] pin_taken;
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1)
        begin : g_pin
            localparam bit IS_IN_ONLY = (g == `SPC_BIT_IRQPIN);
            localparam bit IS_CLK     = (g == `SPC_BIT_CLKPIN);
            wire taken = IS_CLK ? pin4_taken : 1'b0;
            assign pin_taken[g] = taken;
            // input-only bit never drives
            assign port_oe[g] = port_direction_r[g] & ~IS_IN_ONLY; // [R2] [R9]
            assign o_pin_oe[g] = IS_CLK ? (clk_out | (port_oe[g] & ~crystal)) : port_oe[g];
            assign o_pin[g] = (IS_CLK && clk_out) ? i_osc_clock_x4 : port_latch_r[g];
            assign o_pullup_en[g] = port_pullup_enable_r[g] & ~port_direction_r[g]
                                  & ~taken; // [R5] [R6]
            // read latch when output, synced pin when input; bit 2 reads synced pin, or 0 with irq enabled
            if (IS_IN_ONLY)
            begin : g_irqbit
                assign port_read[g] = irq_pin_en ? 1'b0 : pin_sync_r[g]; // [R10] [R11]
            end
            else
            begin : g_iobit
                assign port_read[g] = port_direction_r[g] ? port_latch_r[g]
                                                          : pin_sync_r[g]; // [R3] [R4]
            end
            assign o_keypad_irq[g] = keypad_irq_enable_r[g] & ~taken & ~pin_sync_r[g]; // [R15]
        end
    endgenerate

    assign o_branch_irq_level = irq_pin_en ? pin_sync_r[`SPC_BIT_IRQPIN] : 1'b1; // [R10] [R11]
    assign o_crystal_mode     = crystal;

    // interrupt events: keypad falling edge per pin, wakeup rising edge
    // a pin lent to the clock or the crystal raises no keypad event
    wire [WIDTH-1:0] kbi_event  = keypad_irq_enable_r & ~pin_taken
                                & pin_prev_r & ~pin_sync_r; // [R15]
    wire             wake_event = wake_sync_r & ~wake_prev_r;
    wire [7:0]       events     = {1'b0, wake_event, 6'(kbi_event)};
    wire             stat_clr   = rd_en & sel_stat;
    // set wins over read clear
    assign irq_stat_nxt = (stat_clr ? 8'h00 : irq_stat_r) | events;
    assign o_irq        = |(irq_stat_r & irq_mask_r);

    // write strobes, one per register except the read-cleared status
    wire wr_data   = wr_en & sel_data;
    wire wr_dir    = wr_en & sel_dir;
    wire wr_pullup = wr_en & sel_pullup;
    wire wr_kbi    = wr_en & sel_kbi;
    wire wr_option = wr_en & sel_option;
    wire wr_mask   = wr_en & sel_mask;

    // read views; bit 6 of data is the wakeup latch view, no storage behind it
    wire [7:0] data_view   = {1'b0, wake_sync_r, 6'(port_read)}; // [R7] [R8]
    wire [7:0] dir_view    = {2'b00, 6'(port_direction_r)};
    wire [7:0] pullup_view = {clock_out_pin_select_r, 1'b0, 6'(port_pullup_enable_r)};
    wire [7:0] kbi_view    = {2'b00, 6'(keypad_irq_enable_r)};
    wire [7:0] option_view = {5'h00, option_r};
    logic [7:0] rd_mux;

    // read address decode; unmapped offsets read as zero
    always_comb
    begin
        rd_mux = 8'h00;
        if (sel_data)
        begin
            rd_mux = data_view;
        end
        else if (sel_dir)
        begin
            rd_mux = dir_view;
        end
        else if (sel_pullup)
        begin
            rd_mux = pullup_view;
        end
        else if (sel_kbi)
        begin
            rd_mux = kbi_view;
        end
        else if (sel_option)
        begin
            rd_mux = option_view;
        end
        else if (sel_stat)
        begin
            rd_mux = irq_stat_r;
        end
        else if (sel_mask)
        begin
            rd_mux = irq_mask_r;
        end
    end

    // data latch has no reset
    always_ff @(posedge i_clk_sys)
    begin
        if (wr_data)
        begin
            port_latch_r <= i_wdata[WIDTH-1:0]; // [R1] [R4]
        end
    end

    // direction clears on reset, every pin an input
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            port_direction_r <= `SPC_RST_DIR; // [R2]
        end
        else if (wr_dir)
        begin
            port_direction_r <= i_wdata[WIDTH-1:0]; // [R2]
        end
    end

    // pullup enables
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            port_pullup_enable_r <= `SPC_RST_PULLUP;
        end
        else if (wr_pullup)
        begin
            port_pullup_enable_r <= i_wdata[WIDTH-1:0]; // [R5] [R6]
        end
    end

    // clock-out select shares the pullup register
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            clock_out_pin_select_r <= `SPC_RST_CLKOUT;
        end
        else if (wr_pullup)
        begin
            clock_out_pin_select_r <= i_wdata[`SPC_BIT_CLKOUT]; // [R12]
        end
    end

    // keypad interrupt enables
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            keypad_irq_enable_r <= `SPC_RST_KBI;
        end
        else if (wr_kbi)
        begin
            keypad_irq_enable_r <= i_wdata[WIDTH-1:0]; // [R15]
        end
    end

    // irq pin enable and oscillator source
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            option_r <= `SPC_RST_OPTION;
        end
        else if (wr_option)
        begin
            option_r <= i_wdata[2:0]; // [R14]
        end
    end

    // interrupt mask
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            irq_mask_r <= `SPC_RST_MASK;
        end
        else if (wr_mask)
        begin
            irq_mask_r <= i_wdata;
        end
    end

    // sticky interrupt status
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            irq_stat_r <= `SPC_RST_STAT;
        end
        else if (i_ce)
        begin
            irq_stat_r <= irq_stat_nxt;
        end
    end

    // read data stands one cycle after the strobe, zero after other enabled cycles, held while i_ce is low
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            rdata_r <= `SPC_RST_RDATA;
        end
        else if (i_ce)
        begin
            rdata_r <= rd_en ? rd_mux : 8'h00; // [R19]
        end
    end

    // first synchroniser stage for the pin levels
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            pin_meta_r <= '0;
        end
        else if (i_ce)
        begin
            pin_meta_r <= i_pin; // [R19]
        end
    end

    // second synchroniser stage; only this stage is read by logic
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            pin_sync_r <= '0;
        end
        else if (i_ce)
        begin
            pin_sync_r <= pin_meta_r; // [R19]
        end
    end

    // previous level for falling edge detection; low after reset, so no false edge
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            pin_prev_r <= '0;
        end
        else if (i_ce)
        begin
            pin_prev_r <= pin_sync_r;
        end
    end

    // first synchroniser stage for the wakeup latch level
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            wake_meta_r <= 1'b0;
        end
        else if (i_ce)
        begin
            wake_meta_r <= i_wakeup_latch;
        end
    end

    // second synchroniser stage for the wakeup latch level
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            wake_sync_r <= 1'b0;
        end
        else if (i_ce)
        begin
            wake_sync_r <= wake_meta_r; // [R7]
        end
    end

    // previous wakeup level for rising edge detection
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            wake_prev_r <= 1'b0;
        end
        else if (i_ce)
        begin
            wake_prev_r <= wake_sync_r;
        end
    end

    assign o_rdata = rdata_r;
endmodule

// ===== spc_defines.svh
// register offsets, field positions and reset values for the six-bit port
`ifndef SPC_DEFINES_SVH
`define SPC_DEFINES_SVH
`define SPC_OFF_DATA      8'h00
`define SPC_OFF_DIR       8'h01
`define SPC_OFF_PULLUP    8'h02
`define SPC_OFF_KBI_EN    8'h03
`define SPC_OFF_OPTION    8'h04
`define SPC_OFF_IRQ_STAT  8'h05
`define SPC_OFF_IRQ_MASK  8'h06
`define SPC_BIT_WAKE      6
`define SPC_BIT_CLKOUT    7
`define SPC_BIT_IRQ_EN    0
`define SPC_BIT_OSC_LO    1
`define SPC_BIT_OSC_HI    2
`define SPC_BIT_IRQPIN    2
`define SPC_BIT_CLKPIN    4
`define SPC_RST_DIR       6'h00
`define SPC_RST_PULLUP    6'h00
`define SPC_RST_CLKOUT    1'b0
`define SPC_RST_KBI       6'h00
`define SPC_RST_OPTION    3'h0
`define SPC_RST_MASK      8'h00
`define SPC_RST_STAT      8'h00
`define SPC_RST_RDATA     8'h00
`endif

// ===== spc_pkg.sv
// types for the six-bit port
package spc_pkg;
    typedef enum logic [1:0]
    {
        SPC_OSC_INTERNAL,
        SPC_OSC_EXT_CLOCK,
        SPC_OSC_EXT_RC,
        SPC_OSC_CRYSTAL
    } spc_osc_e;
endpackage

// ===== spc_port_asserts.sv
// concurrent checks on the six-bit port outputs
`timescale 1ns/1ps
module spc_port_asserts (
    input wire logic       i_clk_sys,
    input wire logic       i_rst,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic [5:0] o_pin_oe,
    input wire logic [5:0] o_pullup_en,
    input wire logic [5:0] o_keypad_irq,
    input wire logic       o_crystal_mode,
    input wire logic       o_branch_irq_level,
    input wire logic       o_irq
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    sequence s_rel; $fell(i_rst); endsequence
    sequence s_idle; !i_rd ##1 1'b1; endsequence
    property p_oe2; o_pin_oe[2] == 1'b0; endproperty
    property p_pu; (o_pullup_en & o_pin_oe) == 6'h00; endproperty
    property p_rd; s_idle |-> o_rdata == 8'h00; endproperty
    property p_ro; s_rel |-> o_pin_oe == 6'h00; endproperty
    property p_rp; s_rel |-> o_pullup_en == 6'h00; endproperty
    property p_rb; s_rel |-> o_branch_irq_level && !o_irq; endproperty
    property p_rk; s_rel |-> o_keypad_irq == 6'h00; endproperty
    property p_xt; o_crystal_mode |-> !o_pin_oe[4] && !o_pullup_en[4]; endproperty
    a_oe2: assert property (p_oe2) else $error("pin two driven");
    a_pu: assert property (p_pu) else $error("pullup on output");
    a_rd: assert property (p_rd) else $error("read data stale");
    a_ro: assert property (p_ro) else $error("enable after reset");
    a_rp: assert property (p_rp) else $error("pullup after reset");
    a_rb: assert property (p_rb) else $error("branch level after reset");
    a_rk: assert property (p_rk) else $error("keypad after reset");
    a_xt: assert property (p_xt) else $error("pin four in crystal mode");
endmodule
bind spc_port spc_port_asserts chk_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_pin_oe(o_pin_oe), .o_pullup_en(o_pullup_en),
    .o_keypad_irq(o_keypad_irq), .o_crystal_mode(o_crystal_mode),
    .o_branch_irq_level(o_branch_irq_level), .o_irq(o_irq));

// ===== spc_pins_model.sv
// board model: external drivers, pullups and floating pins
`timescale 1ns/1ps
module spc_pins_model (
    input  wire logic       i_clk_sys,
    input  wire logic [5:0] i_pin_out,
    input  wire logic [5:0] i_pin_oe,
    input  wire logic [5:0] i_pullup_en,
    input  wire logic [5:0] i_drive,
    input  wire logic [5:0] i_drive_en,
    output logic      [5:0] o_level
);
    logic [5:0] float_r = 6'h15;
    always @(posedge i_clk_sys) float_r <= ~float_r;
    always_comb
        for (int k = 0; k < 6; k++)
            o_level[k] = i_pin_oe[k] ? i_pin_out[k] : i_drive_en[k] ? i_drive[k] :
                i_pullup_en[k] ? 1'b1 : float_r[k];
endmodule

// ===== spc_port_bench.sv
// self-checking bench for the six-bit port
`timescale 1ns/1ps
`include "spc_defines.svh"
module spc_port_bench;
    logic        clk = 0, rst = 1, wr = 0, rd = 0, wake = 0, osc = 0, crystal_mode, brl, irq;
    logic [7:0]  addr = 0, wdata = 0, rdata, got, exp_v;
    logic [5:0]  pin, pout, oe, pue_o, kbi, lat, dir, pue, drv = 0;
    logic [31:0] seed = 32'ha8c1_dd56;
    int          err_count = 0, checks_done = 0;
    initial forever #50 clk = ~clk;
    spc_pins_model brd_u (.i_clk_sys(clk), .i_pin_out(pout), .i_pin_oe(oe),
        .i_pullup_en(pue_o), .i_drive(drv), .i_drive_en(6'h3f), .o_level(pin));
    spc_port dut_u (.i_clk_sys(clk), .i_rst(rst), .i_ce(1'b1), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_pin(pin), .o_pin(pout), .o_pin_oe(oe),
        .o_pullup_en(pue_o), .i_wakeup_latch(wake), .i_osc_clock_x4(osc),
        .o_crystal_mode(crystal_mode), .o_branch_irq_level(brl), .o_keypad_irq(kbi), .o_irq(irq));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13; v ^= v >> 17; v ^= v << 5; return v;
    endfunction
    task automatic conclude;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e)
        begin
            err_count++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk); wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk); addr <= a; rd <= 1'b1;
        @(posedge clk); rd <= 1'b0;
        #1 got = rdata;
    endtask
    task automatic rd_cmp(input logic [7:0] a, input logic [7:0] e);
        rd_reg(a);
        cmp(got, e);
    endtask
    initial
    begin
        repeat (100000) @(posedge clk);
        err_count++;
        conclude();
    end
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd_cmp(`SPC_OFF_DIR, 8'h00);
        rd_cmp(`SPC_OFF_PULLUP, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk);
            seed = xs(seed);
            {lat, dir, pue} = {seed[5:0], seed[13:8], seed[21:16]};
            drv <= seed[29:24]; wake <= seed[30];
            wr_reg(`SPC_OFF_DATA, {2'b00, lat});
            wr_reg(`SPC_OFF_DIR, {2'b00, dir});
            wr_reg(`SPC_OFF_PULLUP, {2'b00, pue});
            repeat (3) @(posedge clk);
            exp_v = {1'b0, wake, (dir & 6'h3b & lat) | (~(dir & 6'h3b) & drv)};
            rd_cmp(`SPC_OFF_DATA, exp_v);
            cmp({oe, pue_o[1:0]}, {dir & 6'h3b, pue[1:0] & ~dir[1:0]});
            cmp({2'b00, pue_o}, {2'b00, pue & ~dir});
        end
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 cmp({2'b00, pout}, {2'b00, lat});
        wr_reg(`SPC_OFF_OPTION, 8'h01);
        drv <= 6'h04;
        repeat (3) @(posedge clk);
        #1 cmp({7'h00, brl}, 8'h01);
        rd_cmp(`SPC_OFF_DATA, {1'b0, wake, 6'h00});
        @(posedge clk);
        drv <= 6'h00;
        repeat (3) @(posedge clk);
        #1 cmp({7'h00, brl}, 8'h00);
        wr_reg(`SPC_OFF_DATA, 8'h00);
        wr_reg(`SPC_OFF_DIR, 8'h10);
        for (int j = 0; j < 8; j++)
        begin
            seed = xs(seed);
            osc <= seed[0];
            wr_reg(`SPC_OFF_OPTION, {5'h00, j[1:0], 1'b0});
            wr_reg(`SPC_OFF_PULLUP, {j[2], 7'h00});
            exp_v = {5'h00, j[1:0] == 2'b11, j[1:0] != 2'b11, j[2] & !j[0] & osc};
            #1 cmp({crystal_mode, oe[4], pout[4] & oe[4]}, exp_v);
        end
        wr_reg(`SPC_OFF_OPTION, 8'h00);
        wr_reg(`SPC_OFF_DIR, 8'h00);
        #1 cmp({7'h00, brl}, 8'h01);
        @(posedge clk);
        wake <= 1'b0; drv <= 6'h3f;
        wr_reg(`SPC_OFF_KBI_EN, 8'h3f);
        wr_reg(`SPC_OFF_IRQ_MASK, 8'h01);
        rd_reg(`SPC_OFF_IRQ_STAT);
        @(posedge clk);
        drv <= 6'h3e;
        repeat (4) @(posedge clk);
        #1 cmp({kbi, 1'b0, irq}, {6'h01, 1'b0, 1'b1});
        rd_cmp(`SPC_OFF_IRQ_STAT, 8'h01);
        cmp({7'h00, irq}, 8'h00);
        @(posedge clk);
        drv <= 6'h3d;
        repeat (4) @(posedge clk);
        #1 cmp({7'h00, irq}, 8'h00);
        rd_cmp(`SPC_OFF_IRQ_STAT, 8'h02);
        rd_cmp(8'h07, 8'h00);
        conclude();
    end
endmodule
